/* rtl/fec_host.sv */
// Host-side controller that drives the RF front-end mode lines, enables and routing
// Functional notes
// - Shutdown high with path select high puts the front end in mode 3, full transmit and receive.
// - Shutdown high with path select low puts the front end in mode 2, bypass of both paths.
// - Shutdown low with path select low is mode 0, both amplifiers off, lowest power.
// - Shutdown low with path select high is mode 1, standby, the preferred low-power state.
// - Transmission without extended range uses bypass, never a disabled front end.
// - Both mode lines are plain outputs steered by software, not by peripheral routing.
// - Before sleep, mode 3 is left for mode 0 or mode 1.
// - On wake with extended range wanted, mode 3 is the first thing restored.
// - Going from active to bypass waits until radio activity has ended.
// - Bypass is never used as a low-power state.
// - Advertising and connection transmit power are both held at -6 dBm.
// - On the stack-on event the test route register is written to hand the enables over.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "fec_cfg.svh"

module fec_host (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   sleep_enter,
  input  wire logic                   wake_event,
  input  wire logic                   tx_needed,
  input  wire logic                   rf_busy,
  input  wire logic                   stack_on_event,
  input  wire logic                   ll_pa_req,
  input  wire logic                   ll_lna_req,
  output fec_pkg::fec_pins_t          fe_pins,
  output logic                        pa_enable,
  output logic                        lna_enable,
  output logic [7:0]                  adv_tx_power,
  output logic [7:0]                  conn_tx_power,
  output fec_pkg::fec_route_wr_t      route_wr
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [1:0]          req_mode;
  logic [1:0]          cfg;
  logic [1:0]          mode;
  logic                routed;
  fec_pkg::fec_state_t state;
  fec_pkg::fec_state_t next_state;
  logic [1:0]          next_mode;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite decode

  wire wr_go    = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire rd_go    = s_axi_arvalid & ~s_axi_rvalid;
  wire wr_mode  = wr_go & (s_axi_awaddr == `FEC_OFF_MODE) & s_axi_wstrb[0];
  wire wr_cfg   = wr_go & (s_axi_awaddr == `FEC_OFF_CFG) & s_axi_wstrb[0];
  wire wr_hit;
  wire rd_hit;
  logic [31:0] rd_val;

  assign wr_hit = (s_axi_awaddr == `FEC_OFF_MODE) || (s_axi_awaddr == `FEC_OFF_CFG)
               || (s_axi_awaddr == `FEC_OFF_STATUS) || (s_axi_awaddr == `FEC_OFF_TXPWR);
  assign rd_hit = (s_axi_araddr == `FEC_OFF_MODE) || (s_axi_araddr == `FEC_OFF_CFG)
               || (s_axi_araddr == `FEC_OFF_STATUS) || (s_axi_araddr == `FEC_OFF_TXPWR);

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = ~s_axi_rvalid;

  wire [31:0] status_word = {27'h0, routed, (state == fec_pkg::FEC_SLEEP),
                             (state == fec_pkg::FEC_HOLD), mode};

  always_comb begin
    if (s_axi_araddr == `FEC_OFF_MODE) begin
      rd_val = {30'h0, req_mode};
    end else if (s_axi_araddr == `FEC_OFF_CFG) begin
      rd_val = {30'h0, cfg};
    end else if (s_axi_araddr == `FEC_OFF_STATUS) begin
      rd_val = status_word;
    end else if (s_axi_araddr == `FEC_OFF_TXPWR) begin
      rd_val = {16'h0, conn_tx_power, adv_tx_power};
    end else begin
      rd_val = 32'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FEC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `FEC_RESP_OKAY : `FEC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `FEC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? `FEC_RESP_OKAY : `FEC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  wire wake_high = wake_event & cfg[`FEC_CFG_EXT_BIT];

  // Wake with extended range rewrites the request so software sees mode 3 restored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_mode <= `FEC_MODE_RST;
      cfg      <= `FEC_CFG_RST;
    end else begin
      if (wake_high && state == fec_pkg::FEC_SLEEP) begin
        req_mode <= `FEC_MODE_HIGH;
      end else if (wr_mode) begin
        req_mode <= s_axi_wdata[1:0];
      end
      if (wr_cfg) begin
        cfg <= s_axi_wdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing

  // Bypass instead of off whenever the radio still has to transmit
  wire [1:0] awake_mode = (tx_needed && !req_mode[1]) ? `FEC_MODE_BYP : req_mode;
  // Sleep target is only ever mode 0 or 1, never bypass
  wire [1:0] sleep_mode = cfg[`FEC_CFG_STBY_BIT] ? `FEC_MODE_STBY : `FEC_MODE_OFF;
  wire       defer_byp  = (awake_mode == `FEC_MODE_BYP) && (mode == `FEC_MODE_HIGH)
                          && rf_busy;

  always_comb begin
    next_state = state;
    next_mode  = mode;
    case (state)
      fec_pkg::FEC_RUN, fec_pkg::FEC_HOLD: begin
        if (sleep_enter) begin
          next_state = fec_pkg::FEC_SLEEP;
          next_mode  = sleep_mode;
        end else if (defer_byp) begin
          next_state = fec_pkg::FEC_HOLD;
        end else begin
          next_state = fec_pkg::FEC_RUN;
          next_mode  = awake_mode;
        end
      end
      fec_pkg::FEC_SLEEP: begin
        if (wake_high) begin
          next_state = fec_pkg::FEC_RUN;
          next_mode  = `FEC_MODE_HIGH;
        end else if (wake_event) begin
          next_state = fec_pkg::FEC_RUN;
          next_mode  = awake_mode;
        end else begin
          next_mode  = sleep_mode;
        end
      end
      default: begin
        next_state = fec_pkg::FEC_RUN;
        next_mode  = `FEC_MODE_OFF;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= fec_pkg::FEC_RUN;
      mode  <= `FEC_MODE_OFF;
    end else begin
      state <= next_state;
      mode  <= next_mode;
    end
  end

  // Shutdown is the high mode bit, path select the low one
  assign fe_pins.shutdown    = mode[1];
  assign fe_pins.path_select = mode[0];

  ////////////////////////////////////////////////////////////////////////////
  // Link-layer enables, routing and power level

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      routed        <= 1'b0;
      route_wr      <= '0;
      pa_enable     <= 1'b0;
      lna_enable    <= 1'b0;
      adv_tx_power  <= `FEC_TX_PWR_DBM;
      conn_tx_power <= `FEC_TX_PWR_DBM;
    end else begin
      // One write after reset, on the first stack-on event; later events are ignored
      route_wr.valid <= stack_on_event & ~routed;
      route_wr.addr  <= `FEC_ROUTE_ADDR;
      route_wr.data  <= `FEC_ROUTE_DATA;
      if (stack_on_event) begin
        routed <= 1'b1;
      end
      pa_enable     <= routed & ll_pa_req;
      lna_enable    <= routed & ll_lna_req;
      adv_tx_power  <= `FEC_TX_PWR_DBM;
      conn_tx_power <= `FEC_TX_PWR_DBM;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mode_pin_map_a: assert property (
    (state != fec_pkg::FEC_SLEEP && req_mode == `FEC_MODE_HIGH && !sleep_enter)
      |=> (fe_pins.shutdown && fe_pins.path_select))
    else $error("mode 3 request not shown as both lines high");

  // A deferred bypass keeps mode 3 on the pins, so it is left out here
  bypass_pins_a: assert property (
    (state == fec_pkg::FEC_RUN && awake_mode == `FEC_MODE_BYP && !sleep_enter && !defer_byp)
      |=> (fe_pins.shutdown && !fe_pins.path_select))
    else $error("bypass request not shown as shutdown high path low");

  sleep_off_a: assert property (
    (state != fec_pkg::FEC_SLEEP && sleep_enter && !cfg[`FEC_CFG_STBY_BIT])
      |=> (!fe_pins.shutdown && !fe_pins.path_select))
    else $error("sleep to mode 0 not shown as both lines low");

  sleep_stby_a: assert property (
    (state != fec_pkg::FEC_SLEEP && sleep_enter && cfg[`FEC_CFG_STBY_BIT])
      |=> (!fe_pins.shutdown && fe_pins.path_select))
    else $error("sleep to standby not shown as shutdown low path high");

  no_disable_a: assert property (
    (state != fec_pkg::FEC_SLEEP && tx_needed && !sleep_enter) |=> fe_pins.shutdown)
    else $error("front end disabled while transmission needed");

  sleep_target_a: assert property (
    (state != fec_pkg::FEC_SLEEP && sleep_enter)
      |=> (state == fec_pkg::FEC_SLEEP && !fe_pins.shutdown))
    else $error("sleep entered with front end still enabled");

  wake_high_a: assert property (
    (state == fec_pkg::FEC_SLEEP && wake_event && cfg[`FEC_CFG_EXT_BIT])
      |=> (mode == `FEC_MODE_HIGH) ##1 (req_mode == `FEC_MODE_HIGH || $past(wr_mode)))
    else $error("wake did not restore mode 3 first");

  bypass_defer_a: assert property (
    (mode == `FEC_MODE_HIGH && rf_busy && !sleep_enter) |=> (mode != `FEC_MODE_BYP))
    else $error("bypass entered during radio activity");

  sleep_no_bypass_a: assert property (
    (state == fec_pkg::FEC_SLEEP) |-> !mode[1])
    else $error("sleep state with front end enabled");

  tx_power_a: assert property (
    (adv_tx_power == 8'hfa) && (conn_tx_power == 8'hfa))
    else $error("transmit power not -6 dBm");

  route_write_a: assert property (
    (stack_on_event && !routed)
      |=> (route_wr.valid && route_wr.addr == 32'h40030008) ##1 !route_wr.valid)
    else $error("stack-on did not write route register once");

  pa_follow_a: assert property (
    routed && $changed(ll_pa_req) |=> (pa_enable == $past(ll_pa_req)))
    else $error("amplifier enable not following link layer");

  lna_follow_a: assert property (
    routed |=> (lna_enable == $past(ll_lna_req)))
    else $error("receive enable not following link layer");

  reset_low_a: assert property (
    disable iff (1'b0) !aresetn |=> (!fe_pins.shutdown && !fe_pins.path_select))
    else $error("mode lines not low after reset");

endmodule : fec_host

/* rtl/fec_cfg.svh */
// Offsets, field positions, reset values and fixed settings of the front-end controller
`ifndef FEC_CFG_SVH
`define FEC_CFG_SVH

// Register byte offsets on the AXI4-Lite slave
`define FEC_OFF_MODE      12'h000
`define FEC_OFF_CFG       12'h004
`define FEC_OFF_STATUS    12'h008
`define FEC_OFF_TXPWR     12'h00c

// MODE register: requested front-end mode
`define FEC_MODE_LSB      0
`define FEC_MODE_RST      2'h0

// CFG register fields
`define FEC_CFG_EXT_BIT   0
`define FEC_CFG_STBY_BIT  1
`define FEC_CFG_RST       2'h0

// STATUS register fields
`define FEC_ST_MODE_LSB   0
`define FEC_ST_HOLD_BIT   2
`define FEC_ST_SLEEP_BIT  3
`define FEC_ST_ROUTE_BIT  4

// Front-end modes
`define FEC_MODE_OFF      2'h0
`define FEC_MODE_STBY     2'h1
`define FEC_MODE_BYP      2'h2
`define FEC_MODE_HIGH     2'h3

// Radio transmit power, -6 dBm in two's complement
`define FEC_TX_PWR_DBM    8'hfa

// Test signal route control register and the value that hands the enables to the link layer
`define FEC_ROUTE_ADDR    32'h40030008
`define FEC_ROUTE_DATA    32'h00000000

// AXI responses
`define FEC_RESP_OKAY     2'h0
`define FEC_RESP_SLVERR   2'h2

`endif

/* rtl/fec_pkg.sv */
// Types shared by the front-end controller
package fec_pkg;

  typedef enum logic [1:0] {
    FEC_RUN   = 2'b00,
    FEC_HOLD  = 2'b01,
    FEC_SLEEP = 2'b10
  } fec_state_t;

  typedef struct packed {
    logic shutdown;
    logic path_select;
  } fec_pins_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } fec_route_wr_t;

endpackage : fec_pkg

/* bench/fec_fe_model.sv */
// Behavioural model of the external amplifier front end and its route register
module fec_fe_model #(
  parameter logic [31:0] ROUTE_RST = 32'hffffffff  // Unknown at power-up, any value
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire fec_pkg::fec_pins_t     fe_pins,
  input  wire fec_pkg::fec_route_wr_t route_wr,
  input  wire logic                   pa_enable,
  input  wire logic                   lna_enable,
  output logic [1:0]                  mode,
  output logic                        antenna_live,
  output logic                        pa_on,
  output logic                        lna_on,
  output logic [31:0]                 test_signal_route_control,
  output logic [7:0]                  route_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  assign mode = {fe_pins.shutdown, fe_pins.path_select};
  // Modes 0 and 1 cut the antenna off entirely
  assign antenna_live = mode[1];
  assign pa_on = pa_enable & (mode == 2'h3);
  assign lna_on = lna_enable & (mode == 2'h3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_signal_route_control <= ROUTE_RST;
      route_cnt <= 8'h00;
    end else if (route_wr.valid && route_wr.addr == 32'h40030008) begin
      test_signal_route_control <= route_wr.data;
      route_cnt <= route_cnt + 8'h01;
    end
  end
endmodule : fec_fe_model

/* bench/fec_host_test.sv */
// Self-checking bench for the front-end mode controller
module fec_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic sleep_enter = 1'b0, wake_event = 1'b0, tx_needed = 1'b0, rf_busy = 1'b0;
  logic stack_on_event = 1'b0, ll_pa_req = 1'b0, ll_lna_req = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, mode;
  logic [31:0] s_axi_rdata, test_signal_route_control, d;
  logic [7:0] adv_tx_power, conn_tx_power, route_cnt;
  logic pa_enable, lna_enable, antenna_live, pa_on, lna_on;
  logic [1:0] r;
  fec_pkg::fec_pins_t fe_pins;
  fec_pkg::fec_route_wr_t route_wr;
  int err_count = 0;
  int checked = 0;

  always #10 aclk = ~aclk;

  fec_host u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_enter, .wake_event, .tx_needed,
    .rf_busy, .stack_on_event, .ll_pa_req, .ll_lna_req, .fe_pins, .pa_enable, .lna_enable,
    .adv_tx_power, .conn_tx_power, .route_wr);

  fec_fe_model u_fe (.aclk, .aresetn, .fe_pins, .route_wr, .pa_enable, .lna_enable, .mode,
    .antenna_live, .pa_on, .lna_on, .test_signal_route_control, .route_cnt);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // Ready is looked at on the falling edge so the rising edge after it is the handshake
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_awready !== 1'b1);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic pm(input logic [1:0] e);
    repeat (2) @(negedge aclk);
    chk({30'h0, mode}, {30'h0, e});
    // Return on a rising edge so the next stimulus lands there
    @(posedge aclk);
  endtask : pm

  // 0 sleep entry, 1 wake, 2 stack-on
  task automatic pulse(input int k);
    @(posedge aclk);
    if (k == 0) sleep_enter <= 1'b1;
    else if (k == 1) wake_event <= 1'b1;
    else stack_on_event <= 1'b1;
    @(posedge aclk);
    sleep_enter <= 1'b0;
    wake_event <= 1'b0;
    stack_on_event <= 1'b0;
  endtask : pulse

  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    pm(2'h0);
    rd(12'h00c, d, r);
    chk(d, 32'h0000fafa);
    chk({adv_tx_power, conn_tx_power}, 32'hfafa);
    wr(12'h00c, 32'h0, 2'h0);
    rd(12'h00c, d, r);
    chk(d, 32'h0000fafa);
    wr(12'h010, 32'h3, 2'h2);
    rd(12'h010, d, r);
    chk({d[29:0], r}, 32'h2);
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, i, 2'h0);
      pm(i[1:0]);
      chk({31'h0, antenna_live}, i / 2);
    end
    pm(2'h3);
    rf_busy <= 1'b1;
    wr(12'h000, 32'h2, 2'h0);
    pm(2'h3);
    rd(12'h008, d, r);
    chk(d & 32'h7, 32'h7);
    rf_busy <= 1'b0;
    pm(2'h2);
    wr(12'h000, 32'h0, 2'h0);
    tx_needed <= 1'b1;
    pm(2'h2);
    tx_needed <= 1'b0;
    pm(2'h0);
    wr(12'h004, 32'h1, 2'h0);
    wr(12'h000, 32'h3, 2'h0);
    pulse(0);
    pm(2'h0);
    wr(12'h004, 32'h3, 2'h0);
    pm(2'h1);
    pulse(1);
    pm(2'h3);
    rd(12'h000, d, r);
    chk(d & 32'h3, 32'h3);
    ll_pa_req <= 1'b1;
    ll_lna_req <= 1'b1;
    pm(2'h3);
    chk({pa_enable, lna_enable}, 32'h0);
    pulse(2);
    pulse(2);
    pm(2'h3);
    chk({24'h0, route_cnt}, 32'h1);
    chk(test_signal_route_control, 32'h0);
    chk({pa_on, lna_on}, 32'h3);
    ll_pa_req <= 1'b0;
    pm(2'h3);
    chk({pa_enable, lna_enable}, 32'h1);
    rd(12'h008, d, r);
    chk(d & 32'h10, 32'h10);
    // Wake without extended range goes back to the software request
    wr(12'h004, 32'h0, 2'h0);
    pulse(0);
    wr(12'h000, 32'h1, 2'h0);
    pm(2'h0);
    pulse(1);
    pm(2'h1);
    print_verdict;
  end

  // Whole sequence takes well under two thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    print_verdict;
  end
endmodule : fec_host_test
